// [dcc_defines.svh]
// Constants for the dual comparator control block: register offsets,
// field positions, reset values, mode codes and the phase divider.
// Assumes inclusion by bare name from the package and the top module.
`ifndef DCC_DEFINES_SVH
`define DCC_DEFINES_SVH

// Byte offsets of the word registers on the bus
`define DCC_OFS_CONFIG    5'h00
`define DCC_OFS_FLAG      5'h04
`define DCC_OFS_ENABLE    5'h08
`define DCC_OFS_PORT_DATA 5'h0C
`define DCC_OFS_PORT_DIR  5'h10

// Configuration register fields
`define DCC_CFG_MODE_LSB  0
`define DCC_CFG_SWITCH    3
`define DCC_CFG_INV_LSB   4
`define DCC_CFG_OUT_LSB   6

// Enable register fields
`define DCC_EN_CHG_LSB    0
`define DCC_EN_PERIPH     2
`define DCC_EN_GLOBAL     3

// Reset values
`define DCC_RST_CONFIG    6'h00
`define DCC_RST_DIR       6'h3F

// Comparator mode codes
`define DCC_MODE_OFF_ANA  3'h0
`define DCC_MODE_MUX3     3'h1
`define DCC_MODE_MUX4     3'h2
`define DCC_MODE_COMREF   3'h3
`define DCC_MODE_INDEP2   3'h4
`define DCC_MODE_INDEP1   3'h5
`define DCC_MODE_EXT_OUT  3'h6
`define DCC_MODE_OFF_DIG  3'h7

// Analog pin masks per mode group
`define DCC_ANA_ALL       6'h0F
`define DCC_ANA_TWO_ONLY  6'h0A
`define DCC_ANA_NONE      6'h00
`define DCC_DIG_OUT_PINS  6'h30
`define DCC_OUT_PIN_LSB   4

// System clock cycles per instruction cycle (four quarter phases)
`define DCC_PHASES        4
`define DCC_PHASE_W       2

`endif

// [dcc_pkg.sv]
// Types shared by the dual comparator control block.
// Assumes dcc_defines.svh is on the include path.
package dcc_pkg;
  `include "dcc_defines.svh"

  // Software-written part of the configuration register
  typedef struct packed {
    logic [1:0] output_invert_bit;
    logic       input_switch_select;
    logic [2:0] comparator_mode_field;
  } dcc_cfg_s;

  // Interrupt enable bits
  typedef struct packed {
    logic       global_irq_enable;
    logic       peripheral_irq_enable;
    logic [1:0] comparator_change_irq_enable;
  } dcc_irq_en_s;
endpackage

// [dcc_top.sv]
// Dual comparator control: polarity, mode decode, pin roles, input
// switch, mismatch detection and change flags behind an Avalon-MM slave.
// Assumes raw comparator results and pin levels synchronous to clk_in.
`timescale 1ns/1ns
`include "dcc_defines.svh"

module dcc_top
  import dcc_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        reset_in,
  input  wire logic [4:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  output logic      [31:0] avs_readdata_out,
  output logic             avs_waitrequest_out,
  input  wire logic [1:0]  comp_raw_in,
  input  wire logic [5:0]  pin_level_in,
  output logic      [5:0]  pin_data_out,
  output logic      [5:0]  pin_oe_n_out,
  output logic      [5:0]  pin_analog_out,
  output logic      [1:0]  comp_enable_out,
  output logic      [1:0]  input_switch_out,
  output logic             timer_gate_out,
  output logic             irq_out
);

  // Pins pinned to a digital or analog role by the mode
  function automatic logic [5:0] analog_mask(input logic [2:0] mode);
    case (mode)
      `DCC_MODE_OFF_DIG: analog_mask = `DCC_ANA_NONE;
      `DCC_MODE_INDEP1:  analog_mask = `DCC_ANA_TWO_ONLY;
      default:           analog_mask = `DCC_ANA_ALL;
    endcase
  endfunction

  // Whether comparator idx runs in this mode
  function automatic logic comp_on(input logic [2:0] mode,
                                   input logic       idx);
    case (mode)
      `DCC_MODE_OFF_ANA: comp_on = 1'b0;
      `DCC_MODE_OFF_DIG: comp_on = 1'b0;
      `DCC_MODE_INDEP1:  comp_on = idx;
      default:           comp_on = 1'b1;
    endcase
  endfunction

  // Whether the input switch steers comparator idx in this mode
  function automatic logic switch_on(input logic [2:0] mode,
                                     input logic       idx);
    case (mode)
      `DCC_MODE_MUX3:  switch_on = ~idx;
      `DCC_MODE_MUX4:  switch_on = 1'b1;
      `DCC_MODE_INDEP1: switch_on = idx;
      default:         switch_on = 1'b0;
    endcase
  endfunction

  dcc_cfg_s            cfg_reg;
  dcc_irq_en_s         irq_en_reg;
  logic [1:0]          flag_reg;
  logic [1:0]          sample_reg;
  logic [1:0]          ref_reg;
  logic [1:0]          live;
  logic [1:0]          mismatch;
  logic [5:0]          port_latch_reg;
  logic [5:0]          dir_reg;
  logic [`DCC_PHASE_W-1:0] phase_reg;
  logic                first_quarter_phase;
  logic                wait_reg;
  logic [31:0]         rdata_reg;
  logic [31:0]         rdata_next;
  logic                acc_rd;
  logic                acc_wr;
  logic                cfg_touch;
  logic [5:0]          ana_now;

  assign ana_now = analog_mask(cfg_reg.comparator_mode_field);
  // The analog mask decode feeds the pin roles and the read mask, and a
  // second decode of the same mode sets the comparator power, so a mode change reaches all of them in the same cycle.
  // Powering a comparator up can flip its output and set a change
  // flag, which is why software masks interrupts around mode changes.

  // Bus request accepted on the edge where waitrequest is low
  assign acc_rd = avs_read_in  & ~wait_reg;
  assign acc_wr = avs_write_in & ~wait_reg & avs_byteenable_in[0];
  // Any read or write of config reloads the reference latches
  // A write with lane 0 off still counts here: every write implies a
  // read of config, even when nothing is stored.
  assign cfg_touch = (acc_rd | (avs_write_in & ~wait_reg)) &
                     (avs_address_in == `DCC_OFS_CONFIG);

  // Waitrequest: one wait cycle per request, then release
  // The wait cycle lets the read mux settle into rdata_reg, so read
  // data leave straight from a flop. A request still held after the
  // answer edge starts a fresh transfer.
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      wait_reg <= 1'b1;
    end else if (wait_reg) begin
      wait_reg <= ~(avs_read_in | avs_write_in);
    end else begin
      wait_reg <= 1'b1;
    end
  end

  // Quarter phase divider; pulse marks the first quarter
  // It free-runs from reset; besides config accesses, only one clock in
  // four loads the phase latch, so a change is seen at most four clocks late.
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      phase_reg <= '0;
    end else begin
      phase_reg <= phase_reg + `DCC_PHASE_W'(1);
    end
  end
  assign first_quarter_phase = (phase_reg == '0);

  // Per-comparator output forming and mismatch latches
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_comp
      // Raw high means noninverting above inverting, then polarity
      assign live[gi] = comp_on(cfg_reg.comparator_mode_field, 1'(gi)) &
                        (comp_raw_in[gi] ^
                         cfg_reg.output_invert_bit[gi]);

      // Phase latch, also reloaded by a config access
      always_ff @(posedge clk_in) begin
        if (reset_in) begin
          sample_reg[gi] <= 1'b0;
        end else if (first_quarter_phase | cfg_touch) begin
          sample_reg[gi] <= live[gi];
        end
      end

      // Reference latch, loaded only by config access
      always_ff @(posedge clk_in) begin
        if (reset_in) begin
          ref_reg[gi] <= 1'b0;
        end else if (cfg_touch) begin
          ref_reg[gi] <= live[gi];
        end
      end

      // A change shows here one phase pulse after it reaches live and
      // stays until a config access reloads both latches or the
      // output returns to the referenced level.
      assign mismatch[gi] = sample_reg[gi] ^ ref_reg[gi];

      // Change flag: software writes it, a mismatch sets it and wins
      // A clear during a mismatch is overridden at once, so software
      // must end the mismatch before the clear will stick.
      always_ff @(posedge clk_in) begin
        if (reset_in) begin
          flag_reg[gi] <= 1'b0;
        end else if (acc_wr && avs_address_in == `DCC_OFS_FLAG) begin
          flag_reg[gi] <= avs_writedata_in[gi] | mismatch[gi];
        end else if (mismatch[gi]) begin
          flag_reg[gi] <= 1'b1;
        end
      end
    end
  endgenerate

  // Configuration register; reset puts both comparators in mode 000
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      cfg_reg <= `DCC_RST_CONFIG;
    end else if (acc_wr && avs_address_in == `DCC_OFS_CONFIG) begin
      cfg_reg <= avs_writedata_in[`DCC_CFG_OUT_LSB-1:0];
    end
  end

  // Interrupt enables
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      irq_en_reg <= '0;
    end else if (acc_wr && avs_address_in == `DCC_OFS_ENABLE) begin
      irq_en_reg <= avs_writedata_in[`DCC_EN_GLOBAL:0];
    end
  end

  // Port data latch and direction bits
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      port_latch_reg <= '0;
      dir_reg        <= `DCC_RST_DIR;
    end else if (acc_wr && avs_address_in == `DCC_OFS_PORT_DATA) begin
      port_latch_reg <= avs_writedata_in[5:0];
    end else if (acc_wr && avs_address_in == `DCC_OFS_PORT_DIR) begin
      dir_reg <= avs_writedata_in[5:0];
    end
  end

  // Read data selection; unmapped addresses read zero
  always_comb begin
    rdata_next = '0;
    case (avs_address_in)
      `DCC_OFS_CONFIG: begin
        rdata_next[7:0] = {sample_reg, cfg_reg};
      end
      `DCC_OFS_FLAG: begin
        rdata_next[1:0] = flag_reg;
      end
      `DCC_OFS_ENABLE: begin
        rdata_next[`DCC_EN_GLOBAL:0] = irq_en_reg;
      end
      `DCC_OFS_PORT_DATA: begin
        rdata_next[5:0] = pin_level_in & ~ana_now;
      end
      `DCC_OFS_PORT_DIR: begin
        rdata_next[5:0] = dir_reg;
      end
      default: begin
        rdata_next = '0;
      end
    endcase
  end

  // Read data loaded in the wait cycle, stands in the answer cycle
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      rdata_reg <= '0;
    end else if (wait_reg & avs_read_in) begin
      rdata_reg <= rdata_next;
    end
  end
  assign avs_readdata_out    = rdata_reg;
  assign avs_waitrequest_out = wait_reg;

  // Pin drive: comparator outputs replace port data only in mode 110
  // Direction bits pass straight to the output enables; the two
  // output pins show nothing until software clears their bits.
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      pin_data_out   <= '0;
      pin_oe_n_out   <= '1;
      pin_analog_out <= `DCC_ANA_ALL;
    end else begin
      pin_oe_n_out   <= dir_reg;
      pin_analog_out <= ana_now;
      if (cfg_reg.comparator_mode_field == `DCC_MODE_EXT_OUT) begin
        pin_data_out <= (port_latch_reg & ~`DCC_DIG_OUT_PINS) |
                        {sample_reg, 4'h0};
      end else begin
        pin_data_out <= port_latch_reg;
      end
    end
  end

  // Comparator enables and input-switch steering
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      comp_enable_out  <= '0;
      input_switch_out <= '0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        comp_enable_out[i]  <= comp_on(cfg_reg.comparator_mode_field,
                                       i[0]);
        input_switch_out[i] <= cfg_reg.input_switch_select &
                               switch_on(cfg_reg.comparator_mode_field,
                                         i[0]);
      end
    end
  end

  // Timer gate from comparator two only; interrupt needs global, peripheral and the set flag's own enable
  // The request is a level that stays up while any enabled flag is
  // set; the flags themselves are set whatever the enables hold.
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      timer_gate_out <= 1'b0;
      irq_out        <= 1'b0;
    end else begin
      timer_gate_out <= sample_reg[1];
      irq_out <= |(flag_reg & irq_en_reg.comparator_change_irq_enable) &
                 irq_en_reg.peripheral_irq_enable &
                 irq_en_reg.global_irq_enable;
    end
  end

endmodule

// [dcc_analog_model.sv]
// Analog side of the block: two comparators and six pads.
// Assumes one byte of voltage code per comparator input.
`timescale 1ns/1ns
module dcc_analog_model (
  input  wire logic [15:0] v_plus_in,
  input  wire logic [15:0] v_minus_in,
  input  wire logic [1:0]  switch_in,
  input  wire logic [5:0]  pin_ext_in,
  input  wire logic [5:0]  pin_data_in,
  input  wire logic [5:0]  pin_oe_n_in,
  output logic      [1:0]  comp_raw_out,
  output logic      [5:0]  pin_level_out
);
  // High when plus is above minus; the switch picks another minus
  assign comp_raw_out[0] = v_plus_in[7:0] >
    (switch_in[0] ? ~v_minus_in[7:0] : v_minus_in[7:0]);
  assign comp_raw_out[1] = v_plus_in[15:8] >
    (switch_in[1] ? ~v_minus_in[15:8] : v_minus_in[15:8]);
  // Pads show the block's drive when enabled, else the outside level
  assign pin_level_out = (pin_data_in & ~pin_oe_n_in) |
                         (pin_ext_in & pin_oe_n_in);
endmodule

// [dcc_top_properties.sv]
// Port checker for the comparator control block.
// Assumes a bind to dcc_top; shadows config, enable and port writes.
`timescale 1ns/1ns
module dcc_top_properties (
  input wire logic        clk_in,
  input wire logic        reset_in,
  input wire logic [4:0]  avs_address_in,
  input wire logic        avs_read_in,
  input wire logic        avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0]  avs_byteenable_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic        avs_waitrequest_out,
  input wire logic [5:0]  pin_data_out,
  input wire logic [5:0]  pin_oe_n_out,
  input wire logic [5:0]  pin_analog_out,
  input wire logic [1:0]  comp_enable_out,
  input wire logic [1:0]  input_switch_out,
  input wire logic        irq_out
);
  logic [3:0] cfg_reg;
  logic [3:0] en_reg;
  logic [5:0] lat_sh;
  logic [5:0] dir_sh;
  logic [2:0] m;
  logic       take;
  // Accepted write on the low byte lane
  assign take = avs_write_in && !avs_waitrequest_out && avs_byteenable_in[0];
  assign m = cfg_reg[2:0];
  // Shadow of mode, switch and enable bits
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      cfg_reg <= 4'h0;
      en_reg  <= 4'h0;
    end else if (take && avs_address_in == 5'h00) begin
      cfg_reg <= avs_writedata_in[3:0];
    end else if (take && avs_address_in == 5'h08) begin
      en_reg <= avs_writedata_in[3:0];
    end
  end
  // Shadow of port data and direction writes
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      lat_sh <= 6'h00;
      dir_sh <= 6'h3F;
    end else if (take && avs_address_in == 5'h0C) begin
      lat_sh <= avs_writedata_in[5:0];
    end else if (take && avs_address_in == 5'h10) begin
      dir_sh <= avs_writedata_in[5:0];
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);
  sequence s_waiting;
    (avs_read_in || avs_write_in) && avs_waitrequest_out;
  endsequence
  a_wait_single: assert property (s_waiting |=> !avs_waitrequest_out ##1
    avs_waitrequest_out) else $error("waitrequest not one cycle low");
  a_reset_state: assert property (disable iff (1'b0) reset_in |=>
    pin_oe_n_out == 6'h3F && pin_analog_out == 6'h0F &&
    comp_enable_out == 2'h0 && !irq_out) else $error("reset state");
  a_analog_mask: assert property (pin_analog_out ==
    (($past(m) == 3'h7) ? 6'h00 : ($past(m) == 3'h5) ? 6'h0A : 6'h0F))
    else $error("analog pin mask");
  a_comp_power: assert property (comp_enable_out[1] ==
    ($past(m) != 3'h0 && $past(m) != 3'h7) && comp_enable_out[0] ==
    (comp_enable_out[1] && $past(m) != 3'h5)) else $error("power");
  a_switch_modes: assert property (input_switch_out ==
    {$past(cfg_reg[3]) && ($past(m) == 3'h2 || $past(m) == 3'h5),
     $past(cfg_reg[3]) && ($past(m) == 3'h1 || $past(m) == 3'h2)})
    else $error("input switch");
  a_irq_gated: assert property (irq_out |->
    $past(en_reg[3:2]) == 2'h3 && $past(en_reg[1:0]) != 2'h0)
    else $error("irq without enables");
  a_port_analog: assert property (avs_read_in && !avs_waitrequest_out &&
    avs_address_in == 5'h0C |-> (avs_readdata_out[5:0] & pin_analog_out)
    == 6'h00) else $error("analog pin read not zero");
  a_unmapped_zero: assert property (avs_read_in && !avs_waitrequest_out &&
    avs_address_in > 5'h10 |-> avs_readdata_out == 32'h0)
    else $error("unmapped read not zero");
  a_oe_follows_dir: assert property (pin_oe_n_out == $past(dir_sh))
    else $error("output enable differs from direction");
  a_port_passthru: assert property (pin_data_out[3:0] ==
    $past(lat_sh[3:0]) && ($past(m) == 3'h6 ||
    pin_data_out[5:4] == $past(lat_sh[5:4])))
    else $error("port data not passed through");
endmodule
bind dcc_top dcc_top_properties u_props (.*);

// [tb_dual_comparator_control.sv]
// Bench for the dual comparator control block.
// Assumes the design, its checker and the analog model compiled first.
`timescale 1ns/1ns
module tb_dual_comparator_control;
  logic        clk_in = 1'b0, reset_in = 1'b1;
  logic        avs_read_in = 1'b0, avs_write_in = 1'b0;
  logic [3:0]  avs_byteenable_in = 4'hF;
  logic [4:0]  avs_address_in = 5'h00;
  logic [31:0] avs_writedata_in = 32'h0, avs_readdata_out, rd;
  logic        avs_waitrequest_out, timer_gate_out, irq_out;
  logic [1:0]  comp_raw_in, comp_enable_out, input_switch_out, inv, e;
  logic [5:0]  pin_level_in, pin_data_out, pin_oe_n_out, pin_analog_out;
  logic [5:0]  ext = 6'h00;
  logic [2:0]  mode;
  logic        sw;
  logic [15:0] vp = 16'h0000, vn = 16'h0000;
  integer      seed = 58766, miscompares = 0, tests_run = 0, cycles = 0;
  dcc_top uut (.*);
  dcc_analog_model model (.v_plus_in(vp), .v_minus_in(vn),
    .switch_in(input_switch_out), .pin_ext_in(ext),
    .pin_data_in(pin_data_out), .pin_oe_n_in(pin_oe_n_out),
    .comp_raw_out(comp_raw_in), .pin_level_out(pin_level_in));
  // Clock and hang limit
  initial forever #4 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    cycles = cycles + 1;
    if (cycles == 3000) begin
      miscompares = miscompares + 1;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run = tests_run + 1;
    if (got !== exp) begin
      miscompares = miscompares + 1;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Rule-based expectations: digital-read mask and comparator outputs
  function automatic logic [5:0] exp_ana(input logic [2:0] md);
    exp_ana = (md == 3'h7) ? 6'h00 : (md == 3'h5) ? 6'h0A : 6'h0F;
  endfunction
  function automatic logic [1:0] exp_out(input logic [2:0] md,
    input logic [1:0] iv, input logic s, input logic [15:0] p,
    input logic [15:0] n);
    logic [1:0] on, sel;
    logic [7:0] n1, n0;
    on[1] = md != 3'h0 && md != 3'h7;
    on[0] = on[1] && md != 3'h5;
    sel[1] = s && (md == 3'h2 || md == 3'h5);
    sel[0] = s && (md == 3'h1 || md == 3'h2);
    n1 = sel[1] ? ~n[15:8] : n[15:8];
    n0 = sel[0] ? ~n[7:0] : n[7:0];
    exp_out = on & ({p[15:8] > n1, p[7:0] > n0} ^ iv);
  endfunction
  // One transfer, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [4:0] a,
                     input logic [31:0] d);
    avs_write_in     <= w;
    avs_read_in      <= ~w;
    avs_address_in   <= a;
    avs_writedata_in <= d;
    do @(posedge clk_in); while (avs_waitrequest_out !== 1'b0);
    rd = avs_readdata_out;
    avs_write_in <= 1'b0;
    avs_read_in  <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic rdc(input logic [4:0] a, input logic [31:0] x);
    bus(1'b0, a, 32'h0);
    chk(rd, x);
  endtask
  // New input levels, then two phase-latch periods
  task automatic set_v(input logic [15:0] p, input logic [15:0] n);
    vp <= p;
    vn <= n;
    repeat (8) @(posedge clk_in);
  endtask
  initial begin
    repeat (8) @(posedge clk_in);
    reset_in <= 1'b0;
    @(posedge clk_in);
    rdc(5'h00, 32'h0);
    rdc(5'h10, 32'h3F);
    rdc(5'h14, 32'h0);
    // Every mode with the switch set and interrupts kept masked
    for (int m = 0; m < 8; m++) begin
      ext <= 6'($random(seed));
      bus(1'b1, 5'h00, 32'(m + 8));
      rdc(5'h0C, 32'(ext & ~exp_ana(3'(m))));
    end
    bus(1'b1, 5'h10, 32'h0F);
    bus(1'b1, 5'h0C, 32'h30);
    // Random modes, polarities and levels, output mode first
    for (int i = 0; i < 16; i++) begin
      mode = (i == 0) ? 3'h6 : 3'($random(seed));
      inv = 2'($random(seed));
      sw = 1'($random(seed));
      bus(1'b1, 5'h00, 32'({inv, sw, mode}));
      set_v(16'($random(seed)), 16'($random(seed)));
      e = exp_out(mode, inv, sw, vp, vn);
      rdc(5'h00, 32'({e, inv, sw, mode}));
      chk(32'(pin_data_out[5:4]), 32'(mode == 3'h6 ? e : 2'h3));
      chk(32'(timer_gate_out), 32'(e[1]));
    end
    // Change flag set by hardware, held, then cleared and set
    bus(1'b1, 5'h00, 32'h4);
    set_v(16'h0000, 16'h0101);
    rdc(5'h00, 32'h4);
    bus(1'b1, 5'h04, 32'h0);
    rdc(5'h04, 32'h0);
    set_v(16'h00FF, 16'h0101);
    rdc(5'h04, 32'h1);
    bus(1'b1, 5'h04, 32'h0);
    rdc(5'h04, 32'h1);
    bus(1'b1, 5'h00, 32'h4);
    bus(1'b1, 5'h04, 32'h0);
    rdc(5'h04, 32'h0);
    bus(1'b1, 5'h04, 32'h2);
    // Request only with global, peripheral and the set flag's own enable; flag stays regardless
    for (int k = 0; k < 3; k++) begin
      bus(1'b1, 5'h08, (k == 1) ? 32'hE : 32'hB + 32'(k));
      repeat (2) @(posedge clk_in);
      chk(32'(irq_out), 32'(k == 1));
    end
    bus(1'b1, 5'h08, 32'h0);
    rdc(5'h04, 32'h2);
    // Reset in mid-run returns every register to its reset value
    reset_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    reset_in <= 1'b0;
    @(posedge clk_in);
    rdc(5'h00, 32'h0);
    rdc(5'h04, 32'h0);
    rdc(5'h10, 32'h3F);
    stop_test();
  end
endmodule
